// ==== rtl/mbag_pkg.sv ====
package mbag_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] REG_X_BUFFER_START = 4'h0;
    localparam logic [3:0] REG_X_BUFFER_END = 4'h1;
    localparam logic [3:0] REG_Y_BUFFER_START = 4'h2;
    localparam logic [3:0] REG_Y_BUFFER_END = 4'h3;
    localparam logic [3:0] REG_ADDRESS_MODE_CONTROL = 4'h4;
    localparam logic [3:0] REG_BIT_REVERSE_CONTROL = 4'h5;
    localparam logic [3:0] REG_TABLE_PAGE = 4'h6;
    localparam logic [3:0] REG_VISIBILITY_PAGE = 4'h7;
    localparam logic [3:0] REG_CORE_CONTROL = 4'h8;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int X_SEL_LSB = 0;
    localparam int Y_SEL_LSB = 4;
    localparam int BR_SEL_LSB = 8;
    localparam int X_EN_BIT = 15;
    localparam int Y_EN_BIT = 14;
    localparam int BR_EN_BIT = 15;
    localparam int VIS_EN_BIT = 2;
    localparam int CFG_PAGE_BIT = 7;
    localparam int MAP_EA_BIT = 15;
    localparam logic [3:0] SEL_OFF = 4'hF;
    localparam logic [15:0] RST_BUF = 16'h0000;
    localparam logic [15:0] RST_MODE = 16'h0FFF;
    localparam logic [15:0] RST_BREV = 16'h0000;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [15:0] RST_CORE = 16'h0000;

    // ****************************************************************
    // Access kinds and carriers
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_INDIRECT = 3'b000,
        MODE_POST_INC = 3'b001,
        MODE_POST_DEC = 3'b010,
        MODE_PRE_INC = 3'b011,
        MODE_PRE_DEC = 3'b100,
        MODE_REG_OFFSET = 3'b101
    } mbag_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic y_space;
        logic byte_access;
        logic [3:0] pointer_sel;
        mbag_mode_t mode;
        logic [15:0] pointer;
        logic [15:0] offset;
    } mbag_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] ea;
        logic writeback;
        logic [15:0] new_pointer;
        logic circular;
        logic bitrev;
    } mbag_rsp_t;

    typedef struct packed {
        logic valid;
        logic table_access;
        logic [15:0] ea;
        logic [21:0] pc;
    } mbag_preq_t;

    typedef struct packed {
        logic valid;
        logic mapped;
        logic config_space;
        logic [23:0] addr;
    } mbag_prsp_t;

endpackage

// ==== rtl/mbag_top.sv ====
`timescale 1ns/10ps
// Contract
// - Four 16-bit circular buffer boundary registers.
// - Y circular addresses keep bit zero clear.
// - Length from start and end, up to 32K words.
// - X select in control 3:0, 15 disables.
// - X circular needs select not 15, bit 15.
// - Y select 7:4, enable bit 14.
// - Compare beyond boundaries, overshoots still corrected.
// - Write back only for pre or post modify.
// - Bit reversal only for X data writes.
// - Reverse modifier bits, add with reversed carry.
// - Bit reversal needs select, enable, increment mode.
// - Modifier in bits 14:0, scaled to bytes.
// - Byte writes or other modes: normal address.
// - Reversed modifier replaces increment, bit zero clear.
// - Bit reversal wins over X write circular.
// - Table address is page above effective address.
// - Mapped address is page above fifteen bits.
// - Mapped bit 15 from page bit 0, 23 zero.
// - Mapping needs EA bit 15 and visibility enable.
module mbag_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire mbag_pkg::mbag_req_t req,
    output mbag_pkg::mbag_rsp_t rsp,
    input wire mbag_pkg::mbag_preq_t preq,
    output mbag_pkg::mbag_prsp_t prsp
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0] x_start;
        logic [15:0] x_end;
        logic [15:0] y_start;
        logic [15:0] y_end;
        logic [15:0] mode_ctl;
        logic [15:0] brev_ctl;
        logic [7:0] tbl_page;
        logic [7:0] vis_page;
        logic [15:0] core_ctl;
        logic [15:0] rdata;
        mbag_pkg::mbag_rsp_t rsp;
        mbag_pkg::mbag_prsp_t prsp;
    } mbag_state_t;

    mbag_state_t st_r;
    mbag_state_t st_nxt;

    logic [15:0] step;
    logic [15:0] raw_ea;
    logic [15:0] mod_addr;
    logic [15:0] lo_b;
    logic [15:0] hi_b;
    logic [15:0] rev_mod;
    logic [15:0] rev_ptr;
    logic [15:0] rev_sum;
    logic [15:0] br_addr;
    logic x_circ_on;
    logic y_circ_on;
    logic circ_hit;
    logic br_on;
    logic inc_mode;
    logic modify_mode;
    logic pre_mode;
    logic [3:0] x_sel;
    logic [3:0] y_sel;
    logic [3:0] br_sel;
    logic x_en;
    logic y_en;
    logic br_en;
    logic x_match;
    logic y_match;
    logic br_match;
    logic step_down;
    logic over_end;
    logic under_start;
    logic [15:0] overshoot_up;
    logic [15:0] overshoot_down;
    logic [15:0] wrap_up;
    logic [15:0] wrap_down;
    logic [15:0] circ_addr;
    logic map_on;
    logic [23:0] code_addr;
    logic [23:0] table_addr;
    logic [23:0] map_addr;

    // Bit reversal of the operands turns the reversed-carry add into an ordinary add.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_rev
            assign rev_mod[gi] = st_r.brev_ctl[14 - gi + ((gi == 15) ? 15 : 0)] & (gi != 15);
            assign rev_ptr[gi] = req.pointer[15 - gi];
            assign br_addr[gi] = rev_sum[15 - gi];
        end
    endgenerate

    // The reversed modifier already sits one place up, which scales it to byte addresses.
    assign rev_sum = rev_ptr + rev_mod;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        inc_mode = (req.mode == mbag_pkg::MODE_PRE_INC) || (req.mode == mbag_pkg::MODE_POST_INC);
        pre_mode = (req.mode == mbag_pkg::MODE_PRE_INC) || (req.mode == mbag_pkg::MODE_PRE_DEC);
        modify_mode = inc_mode || pre_mode || (req.mode == mbag_pkg::MODE_POST_DEC);
        case (req.mode)
            mbag_pkg::MODE_POST_INC, mbag_pkg::MODE_PRE_INC: step = req.offset;
            mbag_pkg::MODE_POST_DEC, mbag_pkg::MODE_PRE_DEC: step = 16'h0000 - req.offset;
            mbag_pkg::MODE_REG_OFFSET: step = req.offset;
            default: step = 16'h0000;
        endcase
        raw_ea = req.pointer + step;
        lo_b = req.y_space ? st_r.y_start : st_r.x_start;
        hi_b = req.y_space ? st_r.y_end : st_r.x_end;
    end

    // ****************************************************************
    // Control fields
    // ****************************************************************
    assign x_sel = st_r.mode_ctl[mbag_pkg::X_SEL_LSB +: 4];
    assign y_sel = st_r.mode_ctl[mbag_pkg::Y_SEL_LSB +: 4];
    assign br_sel = st_r.mode_ctl[mbag_pkg::BR_SEL_LSB +: 4];
    assign x_en = st_r.mode_ctl[mbag_pkg::X_EN_BIT];
    assign y_en = st_r.mode_ctl[mbag_pkg::Y_EN_BIT];
    assign br_en = st_r.brev_ctl[mbag_pkg::BR_EN_BIT];
    assign x_match = (req.pointer_sel == x_sel);
    assign y_match = (req.pointer_sel == y_sel);
    assign br_match = (req.pointer_sel == br_sel);
    assign x_circ_on = (x_sel != mbag_pkg::SEL_OFF) && x_en;
    assign y_circ_on = (y_sel != mbag_pkg::SEL_OFF) && y_en;
    assign br_on = (br_sel != mbag_pkg::SEL_OFF) && br_en && br_match && inc_mode
        && req.write && !req.y_space && !req.byte_access;
    assign circ_hit = req.y_space ? (y_circ_on && y_match)
        : (x_circ_on && x_match && !br_on);

    // ****************************************************************
    // Boundary compare
    // ****************************************************************
    // Greater and less compares let a pointer that jumps past a boundary still wrap.
    assign step_down = step[15];
    assign over_end = (raw_ea > hi_b) && !step_down;
    assign under_start = (raw_ea < lo_b) && step_down;
    assign overshoot_up = raw_ea - hi_b;
    assign overshoot_down = lo_b - raw_ea;
    assign wrap_up = lo_b + overshoot_up - 16'h0001;
    assign wrap_down = hi_b - overshoot_down + 16'h0001;

    // Length is implicit; the 16-bit span covers buffers of up to 32K words.
    always_comb begin
        circ_addr = raw_ea;
        if (circ_hit && over_end) begin
            circ_addr = wrap_up;
        end else if (circ_hit && under_start) begin
            circ_addr = wrap_down;
        end
        if (circ_hit && req.y_space) begin
            circ_addr[0] = 1'b0;
        end
    end

    // ****************************************************************
    // Program address sources
    // ****************************************************************
    assign code_addr = {1'b0, preq.pc, 1'b0};
    assign table_addr = {st_r.tbl_page, preq.ea};
    assign map_addr = {1'b0, st_r.vis_page, preq.ea[14:0]};
    assign map_on = preq.ea[mbag_pkg::MAP_EA_BIT]
        && st_r.core_ctl[mbag_pkg::VIS_EN_BIT];

    // ****************************************************************
    // Response and registers
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 16'h0000;
        mod_addr = circ_addr;
        if (br_on) begin
            mod_addr = {br_addr[15:1], 1'b0};
        end

        st_nxt.rsp.valid = req.valid;
        st_nxt.rsp.circular = req.valid && circ_hit;
        st_nxt.rsp.bitrev = req.valid && br_on;
        st_nxt.rsp.new_pointer = modify_mode ? mod_addr : req.pointer;
        st_nxt.rsp.writeback = req.valid && modify_mode;
        if (req.mode == mbag_pkg::MODE_POST_INC || req.mode == mbag_pkg::MODE_POST_DEC) begin
            st_nxt.rsp.ea = req.pointer;
        end else if (req.mode == mbag_pkg::MODE_INDIRECT) begin
            st_nxt.rsp.ea = req.pointer;
        end else begin
            st_nxt.rsp.ea = mod_addr;
        end

        // ************************************************************
        // Program address
        // ************************************************************
        st_nxt.prsp.valid = preq.valid;
        st_nxt.prsp.mapped = 1'b0;
        st_nxt.prsp.config_space = 1'b0;
        st_nxt.prsp.addr = code_addr;
        if (preq.table_access) begin
            st_nxt.prsp.addr = table_addr;
            st_nxt.prsp.config_space = st_r.tbl_page[mbag_pkg::CFG_PAGE_BIT];
        end else if (map_on) begin
            st_nxt.prsp.mapped = 1'b1;
            st_nxt.prsp.addr = map_addr;
        end

        // ************************************************************
        // Register port
        // ************************************************************
        if (reg_wr) begin
            case (reg_addr)
                mbag_pkg::REG_X_BUFFER_START: st_nxt.x_start = reg_wdata;
                mbag_pkg::REG_X_BUFFER_END: st_nxt.x_end = reg_wdata;
                mbag_pkg::REG_Y_BUFFER_START: st_nxt.y_start = reg_wdata;
                mbag_pkg::REG_Y_BUFFER_END: st_nxt.y_end = reg_wdata;
                mbag_pkg::REG_ADDRESS_MODE_CONTROL: st_nxt.mode_ctl = reg_wdata;
                mbag_pkg::REG_BIT_REVERSE_CONTROL: st_nxt.brev_ctl = reg_wdata;
                mbag_pkg::REG_TABLE_PAGE: st_nxt.tbl_page = reg_wdata[7:0];
                mbag_pkg::REG_VISIBILITY_PAGE: st_nxt.vis_page = reg_wdata[7:0];
                mbag_pkg::REG_CORE_CONTROL: st_nxt.core_ctl = reg_wdata;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                mbag_pkg::REG_X_BUFFER_START: st_nxt.rdata = st_r.x_start;
                mbag_pkg::REG_X_BUFFER_END: st_nxt.rdata = st_r.x_end;
                mbag_pkg::REG_Y_BUFFER_START: st_nxt.rdata = st_r.y_start;
                mbag_pkg::REG_Y_BUFFER_END: st_nxt.rdata = st_r.y_end;
                mbag_pkg::REG_ADDRESS_MODE_CONTROL: st_nxt.rdata = st_r.mode_ctl;
                mbag_pkg::REG_BIT_REVERSE_CONTROL: st_nxt.rdata = st_r.brev_ctl;
                mbag_pkg::REG_TABLE_PAGE: st_nxt.rdata = {8'h00, st_r.tbl_page};
                mbag_pkg::REG_VISIBILITY_PAGE: st_nxt.rdata = {8'h00, st_r.vis_page};
                mbag_pkg::REG_CORE_CONTROL: st_nxt.rdata = st_r.core_ctl;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r.x_start <= mbag_pkg::RST_BUF;
            st_r.x_end <= mbag_pkg::RST_BUF;
            st_r.y_start <= mbag_pkg::RST_BUF;
            st_r.y_end <= mbag_pkg::RST_BUF;
            st_r.mode_ctl <= mbag_pkg::RST_MODE;
            st_r.brev_ctl <= mbag_pkg::RST_BREV;
            st_r.tbl_page <= mbag_pkg::RST_PAGE;
            st_r.vis_page <= mbag_pkg::RST_PAGE;
            st_r.core_ctl <= mbag_pkg::RST_CORE;
            st_r.rdata <= 16'h0000;
            st_r.rsp <= '0;
            st_r.prsp <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign rsp = st_r.rsp;
    assign prsp = st_r.prsp;

endmodule

// ==== tb/mbag_checker.sv ====
`timescale 1ns/10ps
module mbag_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire mbag_pkg::mbag_req_t req,
    input wire mbag_pkg::mbag_rsp_t rsp,
    input wire mbag_pkg::mbag_preq_t preq,
    input wire mbag_pkg::mbag_prsp_t prsp
);
    // ********
    // Port relations
    // ********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    a_wb_mode: assert property (rsp.valid |->
        rsp.writeback == ($past(req.mode) inside {3'h1, 3'h2, 3'h3, 3'h4}))
        else $error("write back flag wrong");
    a_post_ea: assert property (rsp.valid && $past(req.mode) inside {3'h1, 3'h2}
        |-> rsp.ea == $past(req.pointer))
        else $error("post modify address moved");
    a_br_lsb: assert property (rsp.bitrev |-> !rsp.ea[0] && !rsp.new_pointer[0])
        else $error("reversed address odd");
    a_br_only_xw: assert property (rsp.bitrev |-> $past(req.write && !req.y_space
        && !req.byte_access && req.mode inside {3'h1, 3'h3}))
        else $error("reversal on wrong access");
    a_br_no_circ: assert property (rsp.bitrev |-> !rsp.circular)
        else $error("reversal and circular together");
    a_y_lsb: assert property (rsp.circular && rsp.writeback && $past(req.y_space) |->
        !rsp.new_pointer[0])
        else $error("y circular pointer odd");
    a_tbl_addr: assert property (prsp.valid && $past(preq.table_access) |->
        prsp.addr[15:0] == $past(preq.ea) && prsp.config_space == prsp.addr[23])
        else $error("table address wrong");
    a_map_addr: assert property (prsp.mapped |-> !prsp.addr[23] && $past(preq.ea[15])
        && prsp.addr[14:0] == $past(preq.ea[14:0]))
        else $error("mapped address wrong");
    a_code_addr: assert property (prsp.valid && !prsp.mapped && !$past(preq.table_access)
        |-> prsp.addr == {1'b0, $past(preq.pc), 1'b0})
        else $error("code address wrong");
    c_bitrev: cover property (rsp.bitrev);
    c_circ: cover property (rsp.circular && rsp.writeback);
    c_mapped: cover property (prsp.mapped);
endmodule
bind mbag_top mbag_checker u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req(req), .rsp(rsp), .preq(preq), .prsp(prsp));

// ==== tb/mbag_core_model.sv ====
`timescale 1ns/10ps
module mbag_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire mbag_pkg::mbag_req_t req,
    input wire mbag_pkg::mbag_rsp_t rsp,
    output logic [15:0] wreg [16]
);
    // ********
    // Pointer file
    // ********
    mbag_pkg::mbag_req_t req_r;
    // Pointers start at a buffer base whose low bits are zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_r <= '0;
            for (int i = 0; i < 16; i++) wreg[i] <= 16'h1000;
        end else begin
            req_r <= req;
            if (rsp.valid && rsp.writeback) wreg[req_r.pointer_sel] <= rsp.new_pointer;
        end
    end
endmodule

// ==== tb/tb_mbag_top.sv ====
`timescale 1ns/10ps
module tb_mbag_top;
    // ********
    // Bench
    // ********
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] wreg [16];
    logic [15:0] rm [10];
    logic [15:0] cfg [5] = '{16'h8F53, 16'h4F53, 16'hC353, 16'hCFFF, 16'h0353};
    mbag_pkg::mbag_req_t req = '0;
    mbag_pkg::mbag_rsp_t rsp;
    mbag_pkg::mbag_preq_t preq = '0;
    mbag_pkg::mbag_prsp_t prsp;
    integer seed = 32'h567B81A9;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    mbag_top u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .rsp(rsp),
        .preq(preq), .prsp(prsp));
    mbag_core_model u_core (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .wreg(wreg));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(int a, logic [15:0] d);
        @(posedge clk);
        reg_addr <= 4'(a);
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        rm[a] = (a == 9) ? 16'h0000 : (a inside {6, 7}) ? d & 16'h00FF : d;
    endtask
    task automatic rd(int a);
        @(posedge clk);
        reg_addr <= 4'(a);
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", 24'(reg_rdata), 24'(rm[a]));
    endtask
    function automatic logic [15:0] brev(logic [15:0] v);
        for (int i = 0; i < 16; i++) brev[i] = v[15 - i];
    endfunction
    function automatic mbag_pkg::mbag_rsp_t model(mbag_pkg::mbag_req_t q);
        mbag_pkg::mbag_rsp_t r;
        logic inc;
        logic br;
        logic [15:0] s;
        logic [15:0] e;
        logic [15:0] v;
        r = '0;
        inc = q.mode inside {3'h1, 3'h3, 3'h5};
        r.writeback = q.mode inside {3'h1, 3'h2, 3'h3, 3'h4};
        s = q.y_space ? rm[2] : rm[0];
        e = q.y_space ? rm[3] : rm[1];
        br = !q.y_space && q.write && !q.byte_access && q.mode inside {3'h1, 3'h3}
            && rm[4][11:8] != 4'hF && q.pointer_sel == rm[4][11:8] && rm[5][15];
        r.circular = !br && (q.y_space ? (rm[4][7:4] != 4'hF && q.pointer_sel == rm[4][7:4]
            && rm[4][14]) : (rm[4][3:0] != 4'hF && q.pointer_sel == rm[4][3:0] && rm[4][15]));
        v = (q.mode == mbag_pkg::MODE_INDIRECT) ? q.pointer
            : inc ? q.pointer + q.offset : q.pointer - q.offset;
        if (r.circular && inc && v > e) v = s + (v - e - 16'h0001);
        if (r.circular && !inc && v < s) v = e - (s - v) + 16'h0001;
        if (r.circular && q.y_space) v[0] = 1'b0;
        if (br) v = brev(brev(q.pointer) + brev({rm[5][14:0], 1'b0}))
            & 16'hFFFE;
        r.new_pointer = v;
        r.ea = (q.mode inside {3'h3, 3'h4, 3'h5}) ? v : q.pointer;
        r.bitrev = br;
        return r;
    endfunction
    task automatic send(mbag_pkg::mbag_req_t q);
        mbag_pkg::mbag_rsp_t r;
        r = model(q);
        @(posedge clk);
        req <= q;
        @(posedge clk);
        #1 check("ea", 24'(rsp.ea), 24'(r.ea));
        check("writeback", 24'(rsp.writeback), 24'(r.writeback));
        check("bitrev", 24'(rsp.bitrev), 24'(r.bitrev));
        check("valid", 24'(rsp.valid), 24'(q.valid));
        check("circular", 24'(rsp.circular), 24'(r.circular));
        if (r.writeback) check("new_pointer", 24'(rsp.new_pointer), 24'(r.new_pointer));
    endtask
    task automatic psend(mbag_pkg::mbag_preq_t p);
        logic [23:0] a;
        logic m;
        m = !p.table_access && p.ea[15] && rm[8][2];
        a = p.table_access ? {rm[6][7:0], p.ea} : m ? {1'b0, rm[7][7:0], p.ea[14:0]}
            : {1'b0, p.pc, 1'b0};
        @(posedge clk);
        preq <= p;
        @(posedge clk);
        #1 check("addr", prsp.addr, a);
        check("mapped", 24'(prsp.mapped), 24'(m));
        check("pvalid", 24'(prsp.valid), 24'(p.valid));
        check("config_space", 24'(prsp.config_space), 24'(p.table_access & rm[6][7]));
    endtask
    initial begin
        mbag_pkg::mbag_req_t q;
        mbag_pkg::mbag_preq_t p;
        int unsigned k;
        rm = '{default: 16'h0000};
        rm[4] = mbag_pkg::RST_MODE;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 10; a++) rd(a);
        for (int a = 0; a < 10; a++) if (a != 8) wr(a, 16'($random(seed)));
        for (int a = 0; a < 10; a++) rd(a);
        wr(0, 16'h1000);
        wr(1, 16'h103F);
        wr(2, 16'h1800);
        wr(3, 16'h183F);
        // Pointers and steps stay within one buffer length, so one wrap always suffices.
        for (int c = 0; c < 5; c++) begin
            wr(4, cfg[c]);
            wr(5, 16'h8000 | 16'($random(seed) & 15));
            @(posedge clk);
            for (int n = 0; n < 40; n++) begin
                q = 43'({$random(seed), $random(seed)});
                k = $random(seed);
                q.valid = 1'b1;
                q.mode = mbag_pkg::mbag_mode_t'(3'(k % 6));
                q.pointer_sel = k[8] ? 4'h3 : k[9] ? 4'h5 : q.pointer_sel;
                q.pointer = (q.y_space ? 16'h1800 : 16'h1000) + (q.pointer & 16'h003E);
                q.offset = q.offset & 16'h003F;
                send(q);
            end
        end
        @(posedge clk);
        nrst <= 1'b0;
        req <= '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rm = '{default: 16'h0000};
        rm[4] = mbag_pkg::RST_MODE;
        for (int a = 0; a < 10; a++) rd(a);
        wr(0, 16'h1000);
        wr(1, 16'h103F);
        wr(4, 16'h8FF3);
        for (int n = 0; n < 16; n++) begin
            @(posedge clk);
            #1 q = '0;
            q.valid = 1'b1;
            q.pointer_sel = 4'h3;
            q.mode = n[0] ? mbag_pkg::MODE_POST_DEC : mbag_pkg::MODE_PRE_INC;
            q.offset = n[0] ? 16'h0006 : 16'h0014;
            q.pointer = wreg[3];
            send(q);
        end
        for (int v = 0; v < 2; v++) begin
            wr(6, 16'($random(seed)));
            wr(7, 16'($random(seed)));
            wr(8, v ? 16'h0004 : 16'h0000);
            for (int n = 0; n < 20; n++) begin
                p = 40'({$random(seed), $random(seed)});
                p.valid = 1'b1;
                psend(p);
            end
        end
        summarize();
    end
endmodule
